/* hdl/ascc_pkg.sv */
// constants and types shared by the axis start/stop control files
// assumes a single 200 MHz clock domain and an APB register bus
`default_nettype none
package ascc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_STOPMODE = 8'h08;
   localparam logic [7:0] OFS_VEL = 8'h0C;
   localparam logic [7:0] OFS_ACC = 8'h10;
   localparam logic [7:0] OFS_TARGET = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_POS = 8'h1C;
   // command register bits (write one to issue)
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_HOME = 2;
   // configuration register bits
   localparam int CFG_SERVO = 0;
   localparam int CFG_CLOSED = 1;
   localparam int CFG_FWD_EN = 2;
   localparam int CFG_REV_EN = 3;
   localparam int CFG_HOME_EN = 4;
   localparam int CFG_W = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
   // status register bits
   localparam int ST_MOVING = 0;
   localparam int ST_DONE = 1;
   localparam int ST_KILLED = 2;
   localparam int ST_HOMING = 3;
   localparam int ST_REFUSED = 4;
   localparam int ST_DIR = 5;
   // stop mode word fields
   localparam int SM_CMD_LSB = 0;
   localparam int SM_HOME_LSB = 8;
   localparam logic [7:0] STOP_CODE_ZERO = 8'h00;
   localparam logic [7:0] STOP_CODE_DECEL = 8'h01;
   localparam logic [7:0] STOP_CODE_HALT = 8'h02;
   localparam logic [7:0] STOP_CODE_KILL = 8'h03;
   localparam logic [7:0] STOP_CODE_RESET = 8'h02;
   // widths
   localparam int VEL_W = 16;
   localparam int POS_W = 32;
   typedef enum logic [1:0]
   {
      STOP_NONE = 2'b00,
      STOP_DECEL = 2'b01,
      STOP_HALT = 2'b11,
      STOP_KILL = 2'b10
   } ascc_stop_t;
   typedef enum logic [1:0]
   {
      TR_IDLE = 2'b00,
      TR_RUN = 2'b01,
      TR_DECEL = 2'b11
   } ascc_trstate_t;
endpackage
`default_nettype wire

/* hdl/ascc_stop_sel.sv */
// one stored stop-type byte with its decode
// assumes the writer presents a byte together with a one-cycle write enable
`timescale 1ns/1ps
`default_nettype none
module ascc_stop_sel
(
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // byte write
   input wire logic wrEn,
   input wire logic [7:0] wrByte,
   // stored code and decoded type
   output logic [7:0] code,
   output var ascc_pkg::ascc_stop_t kind
);
   typedef struct packed
   {
      logic [7:0] code;
   } ascc_sel_t;
   ascc_sel_t s;
   ascc_sel_t next_s;
   always_comb
   begin
      next_s = s;
      // unknown codes leave the held type unchanged
      if (wrEn && wrByte <= ascc_pkg::STOP_CODE_KILL)
      begin
         next_s.code = wrByte;
      end
   end
   always_ff @(posedge refClk)
   begin
      if (srst)
      begin
         s.code <= ascc_pkg::STOP_CODE_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end
   assign code = s.code;
   always_comb
   begin
      case (s.code)
         ascc_pkg::STOP_CODE_DECEL: kind = ascc_pkg::STOP_DECEL;
         ascc_pkg::STOP_CODE_KILL: kind = ascc_pkg::STOP_KILL;
         default: kind = ascc_pkg::STOP_HALT;
      endcase
   end
endmodule
`default_nettype wire

/* hdl/ascc_traj.sv */
// minimal trajectory integrator: ramps up, runs to target, decelerates or halts
// assumes start, decel and halt are one-cycle pulses; halt beats start and decel
`timescale 1ns/1ps
`default_nettype none
module ascc_traj
(
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // requests
   input wire logic start,
   input wire logic loadAcc,
   input wire logic [ascc_pkg::POS_W-1:0] startTarget,
   input wire logic [ascc_pkg::VEL_W-1:0] startVel,
   input wire logic [ascc_pkg::VEL_W-1:0] startAcc,
   input wire logic decel,
   input wire logic halt,
   // trajectory state
   output logic [ascc_pkg::POS_W-1:0] pos,
   output logic [ascc_pkg::VEL_W-1:0] vel,
   output logic dir,
   output logic moving
);
   typedef struct packed
   {
      ascc_pkg::ascc_trstate_t state;
      logic [ascc_pkg::POS_W-1:0] pos;
      logic [ascc_pkg::VEL_W-1:0] vel;
      logic [ascc_pkg::VEL_W-1:0] velTarget;
      logic [ascc_pkg::VEL_W-1:0] acc;
      logic [ascc_pkg::POS_W-1:0] target;
      logic dir;
   } ascc_tr_t;
   ascc_tr_t s;
   ascc_tr_t next_s;
   logic signed [ascc_pkg::POS_W:0] remain;
   logic [ascc_pkg::VEL_W:0] velSum;
   always_comb
   begin
      next_s = s;
      remain = s.dir ? ($signed({s.target[ascc_pkg::POS_W-1], s.target})
         - $signed({s.pos[ascc_pkg::POS_W-1], s.pos}))
         : ($signed({s.pos[ascc_pkg::POS_W-1], s.pos})
         - $signed({s.target[ascc_pkg::POS_W-1], s.target}));
      velSum = {1'b0, s.vel} + {1'b0, s.acc};
      case (s.state)
         ascc_pkg::TR_IDLE:
         begin
            next_s.vel = '0;
         end
         ascc_pkg::TR_RUN:
         begin
            if (remain <= $signed({{(ascc_pkg::POS_W-ascc_pkg::VEL_W+1){1'b0}}, s.vel}))
            begin
               next_s.pos = s.target;
               next_s.vel = '0;
               next_s.state = ascc_pkg::TR_IDLE;
            end
            else
            begin
               next_s.pos = s.dir ? s.pos + {{(ascc_pkg::POS_W-ascc_pkg::VEL_W){1'b0}}, s.vel}
                  : s.pos - {{(ascc_pkg::POS_W-ascc_pkg::VEL_W){1'b0}}, s.vel};
               if (velSum[ascc_pkg::VEL_W-1:0] < s.velTarget && !velSum[ascc_pkg::VEL_W])
               begin
                  next_s.vel = velSum[ascc_pkg::VEL_W-1:0];
               end
               else
               begin
                  next_s.vel = s.velTarget;
               end
            end
         end
         ascc_pkg::TR_DECEL:
         begin
            next_s.pos = s.dir ? s.pos + {{(ascc_pkg::POS_W-ascc_pkg::VEL_W){1'b0}}, s.vel}
               : s.pos - {{(ascc_pkg::POS_W-ascc_pkg::VEL_W){1'b0}}, s.vel};
            if (s.vel <= s.acc || s.acc == '0)
            begin
               next_s.vel = '0;
               next_s.state = ascc_pkg::TR_IDLE;
            end
            else
            begin
               next_s.vel = s.vel - s.acc;
            end
         end
         default:
         begin
            next_s.state = ascc_pkg::TR_IDLE;
         end
      endcase
      if (start)
      begin
         next_s.target = startTarget;
         next_s.velTarget = startVel;
         if (loadAcc)
         begin
            next_s.acc = startAcc;
         end
         next_s.dir = $signed(startTarget) >= $signed(s.pos);
         next_s.state = ascc_pkg::TR_RUN;
      end
      if (decel && s.state != ascc_pkg::TR_IDLE)
      begin
         next_s.state = ascc_pkg::TR_DECEL;
      end
      if (halt)
      begin
         next_s.vel = '0;
         next_s.state = ascc_pkg::TR_IDLE;
      end
   end
   always_ff @(posedge refClk)
   begin
      if (srst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end
   assign pos = s.pos;
   assign vel = s.vel;
   assign dir = s.dir;
   assign moving = s.state != ascc_pkg::TR_IDLE;
endmodule
`default_nettype wire

/* hdl/ascc_axis_ctrl.sv */
// axis start/stop control top: APB registers, stop arbitration, start checks
// assumes APB master per APB3, switch inputs synchronous to refClk, active high
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ascc_axis_ctrl
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // switches and loop feedback
   input wire logic fwdLimit,
   input wire logic revLimit,
   input wire logic homeSwitch,
   input wire logic followErr,
   // motor driver and command buffer side
   output logic inhibit,
   output logic signed [16:0] motorCtrl,
   output logic cmdPurge,
   output logic moveComplete
);
   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [ascc_pkg::CFG_W-1:0] cfg;
      logic [ascc_pkg::VEL_W-1:0] ldVel;
      logic [ascc_pkg::VEL_W-1:0] ldAcc;
      logic [ascc_pkg::POS_W-1:0] ldTarget;
      logic goStart;
      logic goStop;
      logic goHome;
      logic fwdPrev;
      logic revPrev;
      logic homePrev;
      logic wasMoving;
      logic homing;
      logic moveDone;
      logic refused;
      logic killed;
      logic purge;
      logic signed [16:0] motorCtrl;
   } ascc_top_t;
   ascc_top_t s;
   ascc_top_t next_s;
   // bus decode
   logic access;
   logic wrAcc;
   logic mapped;
   logic wrStopMode;
   // stop type storage
   logic [7:0] cmdCode;
   logic [7:0] homeCode;
   ascc_pkg::ascc_stop_t cmdKind;
   ascc_pkg::ascc_stop_t homeKind;
   // trajectory
   logic trStart;
   logic trLoadAcc;
   logic trDecel;
   logic trHalt;
   logic [ascc_pkg::POS_W-1:0] trPos;
   logic [ascc_pkg::VEL_W-1:0] trVel;
   logic trDir;
   logic trMoving;
   // stop arbitration
   ascc_pkg::ascc_stop_t stopReq;
   logic limFwdEdge;
   logic limRevEdge;
   logic homeEdge;
   logic wantStart;
   logic newDir;
   logic blocked;
   logic servo;
   logic [31:0] status;

   assign access = psel && penable && !s.pready;
   assign wrAcc = access && pwrite;
   assign wrStopMode = wrAcc && paddr == ascc_pkg::OFS_STOPMODE;
   assign servo = s.cfg[ascc_pkg::CFG_SERVO];

   always_comb
   begin
      case (paddr)
         ascc_pkg::OFS_CMD,
         ascc_pkg::OFS_CFG,
         ascc_pkg::OFS_STOPMODE,
         ascc_pkg::OFS_VEL,
         ascc_pkg::OFS_ACC,
         ascc_pkg::OFS_TARGET,
         ascc_pkg::OFS_STATUS,
         ascc_pkg::OFS_POS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // commanded-stop byte and home-switch byte, stored separately
   ascc_stop_sel u_cmdSel
   (
      .refClk(ref_clk),
      .srst(srst),
      .wrEn(wrStopMode),
      .wrByte(pwdata[ascc_pkg::SM_CMD_LSB +: 8]),
      .code(cmdCode),
      .kind(cmdKind)
   );

   ascc_stop_sel u_homeSel
   (
      .refClk(ref_clk),
      .srst(srst),
      .wrEn(wrStopMode),
      .wrByte(pwdata[ascc_pkg::SM_HOME_LSB +: 8]),
      .code(homeCode),
      .kind(homeKind)
   );

   ascc_traj u_traj
   (
      .refClk(ref_clk),
      .srst(srst),
      .start(trStart),
      .loadAcc(trLoadAcc),
      .startTarget(s.ldTarget),
      .startVel(s.ldVel),
      .startAcc(s.ldAcc),
      .decel(trDecel),
      .halt(trHalt),
      .pos(trPos),
      .vel(trVel),
      .dir(trDir),
      .moving(trMoving)
   );

   // switch edges; only an enabled input counts
   assign limFwdEdge = fwdLimit && !s.fwdPrev && s.cfg[ascc_pkg::CFG_FWD_EN];
   assign limRevEdge = revLimit && !s.revPrev && s.cfg[ascc_pkg::CFG_REV_EN];
   assign homeEdge = homeSwitch && !s.homePrev && s.cfg[ascc_pkg::CFG_HOME_EN];

   // most severe cause wins
   always_comb
   begin
      stopReq = ascc_pkg::STOP_NONE;
      if ((s.goStop && cmdKind == ascc_pkg::STOP_DECEL)
         || (s.homing && homeEdge && homeKind == ascc_pkg::STOP_DECEL))
      begin
         stopReq = ascc_pkg::STOP_DECEL;
      end
      if ((s.goStop && cmdKind == ascc_pkg::STOP_HALT)
         || (s.homing && homeEdge && homeKind == ascc_pkg::STOP_HALT)
         || limFwdEdge || limRevEdge
         || (!s.homing && homeEdge))
      begin
         stopReq = ascc_pkg::STOP_HALT;
      end
      if ((s.goStop && cmdKind == ascc_pkg::STOP_KILL)
         || (s.homing && homeEdge && homeKind == ascc_pkg::STOP_KILL)
         || (s.cfg[ascc_pkg::CFG_CLOSED] && followErr))
      begin
         stopReq = ascc_pkg::STOP_KILL;
      end
   end

   assign trHalt = stopReq == ascc_pkg::STOP_HALT || stopReq == ascc_pkg::STOP_KILL;
   assign trDecel = stopReq == ascc_pkg::STOP_DECEL;

   // start checks
   assign wantStart = s.goStart || s.goHome;
   assign newDir = $signed(s.ldTarget) >= $signed(trPos);
   assign blocked = (newDir && fwdLimit && s.cfg[ascc_pkg::CFG_FWD_EN])
      || (!newDir && revLimit && s.cfg[ascc_pkg::CFG_REV_EN]);
   // loaded registers are held, so a bare start reuses them
   assign trStart = wantStart && !blocked && stopReq == ascc_pkg::STOP_NONE
      && !(trMoving && !servo);
   assign trLoadAcc = !(servo && trMoving);

   always_comb
   begin
      status = '0;
      status[ascc_pkg::ST_MOVING] = trMoving;
      status[ascc_pkg::ST_DONE] = s.moveDone;
      status[ascc_pkg::ST_KILLED] = s.killed;
      status[ascc_pkg::ST_HOMING] = s.homing;
      status[ascc_pkg::ST_REFUSED] = s.refused;
      status[ascc_pkg::ST_DIR] = trDir;
   end

   always_comb
   begin
      next_s = s;
      // apb: one wait state, answer registered
      next_s.pready = access;
      next_s.pslverr = access && !mapped;
      next_s.prdata = '0;
      next_s.goStart = 1'b0;
      next_s.goStop = 1'b0;
      next_s.goHome = 1'b0;
      if (access && !pwrite)
      begin
         case (paddr)
            ascc_pkg::OFS_CFG: next_s.prdata = {{(32-ascc_pkg::CFG_W){1'b0}}, s.cfg};
            ascc_pkg::OFS_STOPMODE: next_s.prdata = {16'h0000, homeCode, cmdCode};
            ascc_pkg::OFS_VEL: next_s.prdata = {16'h0000, s.ldVel};
            ascc_pkg::OFS_ACC: next_s.prdata = {16'h0000, s.ldAcc};
            ascc_pkg::OFS_TARGET: next_s.prdata = s.ldTarget;
            ascc_pkg::OFS_STATUS: next_s.prdata = status;
            ascc_pkg::OFS_POS: next_s.prdata = trPos;
            default: next_s.prdata = '0;
         endcase
      end
      if (wrAcc)
      begin
         case (paddr)
            ascc_pkg::OFS_CMD:
            begin
               next_s.goStart = pwdata[ascc_pkg::CMD_START];
               next_s.goStop = pwdata[ascc_pkg::CMD_STOP];
               next_s.goHome = pwdata[ascc_pkg::CMD_HOME];
            end
            ascc_pkg::OFS_CFG: next_s.cfg = pwdata[ascc_pkg::CFG_W-1:0];
            ascc_pkg::OFS_VEL: next_s.ldVel = pwdata[ascc_pkg::VEL_W-1:0];
            ascc_pkg::OFS_ACC: next_s.ldAcc = pwdata[ascc_pkg::VEL_W-1:0];
            ascc_pkg::OFS_TARGET: next_s.ldTarget = pwdata;
            default: next_s.cfg = s.cfg;
         endcase
      end
      next_s.fwdPrev = fwdLimit;
      next_s.revPrev = revLimit;
      next_s.homePrev = homeSwitch;
      next_s.wasMoving = trMoving;
      // home seek runs from an accepted home command until any stop or arrival
      if (s.homing && (stopReq != ascc_pkg::STOP_NONE || (s.wasMoving && !trMoving)))
      begin
         next_s.homing = 1'b0;
      end
      if (s.goHome && trStart)
      begin
         next_s.homing = 1'b1;
      end
      // refusal flag: cleared by the next start attempt, set wins
      if (wantStart)
      begin
         next_s.refused = !trStart;
      end
      // move complete: clear on accepted start, set on end of motion
      if (trStart)
      begin
         next_s.moveDone = 1'b0;
      end
      if (s.wasMoving && !trMoving)
      begin
         next_s.moveDone = 1'b1;
      end
      // a commanded halt or decelerate stop releases the killed state
      if (s.goStop && cmdKind != ascc_pkg::STOP_KILL)
      begin
         next_s.killed = 1'b0;
      end
      next_s.purge = 1'b0;
      if (stopReq == ascc_pkg::STOP_KILL)
      begin
         next_s.killed = 1'b1;
         next_s.purge = 1'b1;
      end
      // signed drive command; zero on stepper axes and while killed
      if (servo && !next_s.killed && !trHalt)
      begin
         next_s.motorCtrl = trDir ? $signed({1'b0, trVel}) : -$signed({1'b0, trVel});
      end
      else
      begin
         next_s.motorCtrl = '0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s <= '0;
         s.cfg <= ascc_pkg::CFG_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign inhibit = s.killed;
   assign motorCtrl = s.motorCtrl;
   assign cmdPurge = s.purge;
   assign moveComplete = s.moveDone;
endmodule
`default_nettype wire

/* tb/ascc_axis_ctrl_asserts.sv */
// checker on the axis start/stop control top ports
// assumes a bind into the top module, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module ascc_axis_ctrl_asserts
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // switches and loop feedback
   input wire logic fwdLimit,
   input wire logic revLimit,
   input wire logic followErr,
   // driver side
   input wire logic inhibit,
   input wire logic signed [16:0] motorCtrl,
   input wire logic cmdPurge
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // shadow of the configuration word
   logic [4:0] cfg;
   logic mapped;
   assign mapped = paddr[1:0] == 2'h0 && paddr <= ascc_pkg::OFS_POS;
   always_ff @(posedge ref_clk)
      if (srst)
         cfg <= 5'h00;
      else if (psel && penable && pwrite && !pready && paddr == ascc_pkg::OFS_CFG)
         cfg <= pwdata[4:0];
   sequence apbTaken;
      psel && penable && !pready;
   endsequence
   sequence apbAnswer;
      pready ##1 !pready;
   endsequence
   apb_answer_a: assert property (apbTaken |=> apbAnswer)
      else $error("apb answer not a single cycle");
   unmapped_err_a: assert property (pready && !mapped |-> pslverr)
      else $error("no error on unmapped address");
   mapped_ok_a: assert property (pready && mapped |-> !pslverr)
      else $error("error on mapped address");
   kill_purge_a: assert property ($rose(inhibit) |-> cmdPurge || $past(cmdPurge))
      else $error("inhibit without purge");
   purge_kill_a: assert property (cmdPurge |-> ##[0:1] inhibit)
      else $error("purge without inhibit");
   killed_zero_a: assert property (inhibit [*3] |-> motorCtrl == 17'sh0)
      else $error("drive not zero while killed");
   follow_kill_a: assert property (followErr && cfg[1] |-> ##[1:2] inhibit)
      else $error("following error did not kill");
   fwd_halt_a: assert property ($rose(fwdLimit) && cfg[2] |-> ##[1:3] motorCtrl == 17'sh0)
      else $error("forward limit did not halt");
   rev_halt_a: assert property ($rose(revLimit) && cfg[3] |-> ##[1:3] motorCtrl == 17'sh0)
      else $error("reverse limit did not halt");
endmodule
`default_nettype wire

/* tb/ascc_drive_model.sv */
// motor driver model: needs a recovery time after inhibit is released
// assumes inhibit high disables the driver
`timescale 1ns/1ps
`default_nettype none
module ascc_drive_model
#(
   parameter int RECOVER = 8
)
(
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // from the block
   input wire logic inhibit,
   // to the host
   output logic drvReady
);
   logic [7:0] cnt;
   always_ff @(posedge refClk)
      if (srst || inhibit)
         cnt <= 8'h00;
      else if (cnt < RECOVER[7:0])
         cnt <= cnt + 8'h01;
   assign drvReady = cnt == RECOVER[7:0];
endmodule
`default_nettype wire

/* tb/ascc_axis_ctrl_tb.sv */
// self-checking bench for the axis start/stop control top
// assumes design files, checker and drive model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ascc_axis_ctrl_tb;
   logic refClk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic fwdLimit, revLimit, homeSwitch, followErr;
   logic inhibit, cmdPurge, moveComplete, drvReady;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [16:0] motorCtrl;
   int nFail = 0;
   int nTests = 0;
   int nPurge = 0;
   ascc_axis_ctrl DUT (.ref_clk(refClk), .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .fwdLimit, .revLimit, .homeSwitch, .followErr, .inhibit,
      .motorCtrl, .cmdPurge, .moveComplete);
   ascc_drive_model #(.RECOVER(8)) drv (.refClk, .srst, .inhibit, .drvReady);
   initial
   begin
      refClk = 1'b0;
      forever #2.5 refClk = ~refClk;
   end
   always @(posedge refClk)
      if (cmdPurge === 1'b1)
         nPurge++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp)
      begin
         nFail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge refClk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge refClk);
      penable <= 1'b1;
      do
         @(posedge refClk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic cmd(input logic [31:0] d);
      apb(1'b1, ascc_pkg::OFS_CMD, d);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic st(input int b, input logic e);
      apb(1'b0, ascc_pkg::OFS_STATUS, 32'h0);
      chk({31'h0, rd[b]}, {31'h0, e});
   endtask
   task automatic mc(input logic [31:0] e);
      chk({{15{motorCtrl[16]}}, motorCtrl}, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge refClk);
   endtask
   // commanded stop, then wait out the driver recovery
   task automatic freeAxis();
      cmd(32'h2);
      settle(3);
      chk({31'h0, inhibit}, 32'h0);
      for (int i = 0; i < 100 && drvReady !== 1'b1; i++)
         @(posedge refClk);
      chk({31'h0, drvReady}, 32'h1);
   endtask
   task automatic note(input string s);
      $display("test %s finished", s);
   endtask
   task automatic finishTest();
      $display("comparisons %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #100us;
      nFail++;
      finishTest();
   end
   initial
   begin
      srst = 1'b1;
      {psel, penable, pwrite, fwdLimit, revLimit, homeSwitch, followErr} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      settle(4);
      srst <= 1'b0;
      rdChk(ascc_pkg::OFS_STOPMODE, 32'h00000202);
      rdChk(ascc_pkg::OFS_CFG, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(ascc_pkg::OFS_STOPMODE, 32'h0103);
      rdChk(ascc_pkg::OFS_STOPMODE, 32'h0103);
      wr(ascc_pkg::OFS_STOPMODE, 32'h0500);
      rdChk(ascc_pkg::OFS_STOPMODE, 32'h0100);
      note("stop word");
      wr(ascc_pkg::OFS_VEL, 32'h8);
      wr(ascc_pkg::OFS_ACC, 32'h1);
      wr(ascc_pkg::OFS_TARGET, 32'h000186A0);
      wr(ascc_pkg::OFS_CFG, 32'h1);
      cmd(32'h1);
      settle(20);
      mc(32'h8);
      st(ascc_pkg::ST_MOVING, 1'b1);
      cmd(32'h2);
      settle(3);
      mc(32'h0);
      note("start and halt");
      wr(ascc_pkg::OFS_STOPMODE, 32'h0201);
      cmd(32'h1);
      settle(20);
      mc(32'h8);
      chk({31'h0, moveComplete}, 32'h0);
      cmd(32'h2);
      settle(3);
      chk({31'h0, motorCtrl > 17'sh0}, 32'h1);
      settle(20);
      st(ascc_pkg::ST_DONE, 1'b1);
      chk({31'h0, moveComplete}, 32'h1);
      note("decelerate");
      cmd(32'h1);
      settle(10);
      wr(ascc_pkg::OFS_ACC, 32'h8);
      wr(ascc_pkg::OFS_TARGET, 32'hFFFFFF9C);
      cmd(32'h1);
      settle(4);
      mc(32'hFFFFFFF8);
      settle(10);
      st(ascc_pkg::ST_DIR, 1'b0);
      st(ascc_pkg::ST_MOVING, 1'b1);
      cmd(32'h2);
      settle(3);
      chk({31'h0, motorCtrl < 17'sh0}, 32'h1);
      cmd(32'h1);
      note("servo override");
      wr(ascc_pkg::OFS_STOPMODE, 32'h0203);
      cmd(32'h2);
      settle(3);
      chk({31'h0, inhibit}, 32'h1);
      chk(nPurge, 32'h1);
      mc(32'h0);
      st(ascc_pkg::ST_KILLED, 1'b1);
      wr(ascc_pkg::OFS_STOPMODE, 32'h0202);
      freeAxis();
      note("kill");
      wr(ascc_pkg::OFS_TARGET, 32'h000186A0);
      wr(ascc_pkg::OFS_CFG, 32'h0);
      cmd(32'h1);
      wr(ascc_pkg::OFS_TARGET, 32'hFFFFFF9C);
      cmd(32'h1);
      st(ascc_pkg::ST_REFUSED, 1'b1);
      st(ascc_pkg::ST_DIR, 1'b1);
      mc(32'h0);
      wr(ascc_pkg::OFS_TARGET, 32'h000186A0);
      cmd(32'h2);
      note("stepper");
      wr(ascc_pkg::OFS_STOPMODE, 32'h0201);
      wr(ascc_pkg::OFS_CFG, 32'hD);
      cmd(32'h1);
      settle(10);
      fwdLimit <= 1'b1;
      revLimit <= 1'b1;
      settle(4);
      mc(32'h0);
      cmd(32'h1);
      st(ascc_pkg::ST_REFUSED, 1'b1);
      fwdLimit <= 1'b0;
      revLimit <= 1'b0;
      note("limits");
      wr(ascc_pkg::OFS_CFG, 32'h3);
      cmd(32'h1);
      settle(5);
      followErr <= 1'b1;
      settle(3);
      chk({31'h0, inhibit}, 32'h1);
      followErr <= 1'b0;
      freeAxis();
      note("following error");
      wr(ascc_pkg::OFS_STOPMODE, 32'h0302);
      wr(ascc_pkg::OFS_CFG, 32'h11);
      cmd(32'h4);
      settle(5);
      homeSwitch <= 1'b1;
      settle(3);
      chk({31'h0, inhibit}, 32'h1);
      homeSwitch <= 1'b0;
      freeAxis();
      cmd(32'h1);
      settle(5);
      homeSwitch <= 1'b1;
      settle(3);
      mc(32'h0);
      chk({31'h0, inhibit}, 32'h0);
      homeSwitch <= 1'b0;
      note("home switch");
      finishTest();
   end
endmodule
bind ascc_axis_ctrl ascc_axis_ctrl_asserts sva (.ref_clk, .srst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .fwdLimit, .revLimit, .followErr, .inhibit,
   .motorCtrl, .cmdPurge);
`default_nettype wire
